// [verif/core_stream_model.sv]
// endpoint core stand-in: feeds tlps on the receive stream, takes completions
// assumes the responder's 32-bit stream ports on one clock; tasks start at a rising edge
`timescale 1ns/100ps
module core_stream_model (
    input  wire logic        i_core_clk,
    input  wire logic        i_rx_tready,
    input  wire logic [31:0] i_tx_tdata,
    input  wire logic        i_tx_tvalid,
    input  wire logic        i_tx_tlast,
    output logic [31:0]      o_rx_tdata,
    output logic             o_rx_tvalid,
    output logic             o_rx_tlast,
    output logic [7:0]       o_rx_bar_hit,
    output logic             o_tx_tready
);
    logic [31:0] cpl_q [$];
    logic        end_q [$];
    bit          slow;

    initial begin
        o_rx_tdata   = 32'h0;
        o_rx_tvalid  = 1'b0;
        o_rx_tlast   = 1'b0;
        o_rx_bar_hit = 8'h00;
        slow         = 1'b0;
    end

    // ==========================================================
    // completion sink
    always @(posedge i_core_clk) begin
        o_tx_tready <= slow ? ~o_tx_tready : 1'b1;
    end

    // sampled mid-cycle so capture never races the responder's edge
    always @(negedge i_core_clk) begin
        if (i_tx_tvalid && o_tx_tready) begin
            cpl_q.push_back(i_tx_tdata);
            end_q.push_back(i_tx_tlast);
        end
    end

    // ==========================================================
    // request source: only bar-matched packets, hit bit held all packet
    task automatic send_tlp(input logic [31:0] dw [5], input int n, input logic [7:0] bar, output bit ok);
        int i;
        int k;
        bit rdy;
        ok = 1'b1;
        for (i = 0; i < n; i++) begin
            o_rx_tdata   <= dw[i];
            o_rx_tvalid  <= 1'b1;
            o_rx_tlast   <= (i == n - 1);
            o_rx_bar_hit <= bar;
            k = 0;
            do begin
                @(negedge i_core_clk);
                rdy = i_rx_tready;
                @(posedge i_core_clk);
                k++;
            end while (!rdy && k < 200);
            if (!rdy) begin
                ok = 1'b0;
                break;
            end
        end
        // released data shows the inverse so a stale beat never looks fresh
        o_rx_tvalid  <= 1'b0;
        o_rx_tlast   <= 1'b0;
        o_rx_tdata   <= ~o_rx_tdata;
        o_rx_bar_hit <= 8'h00;
        // one idle edge, so a following call never re-drives valid in this step
        @(posedge i_core_clk);
    endtask
endmodule

// [verif/pio_target_responder_bench.sv]
// self-checking bench for the pio target responder
// assumes core_stream_model on the stream ports; completer id fixed
`timescale 1ns/100ps
module pio_target_responder_bench;
    logic        core_clk = 1'b0;
    logic        reset_n = 1'b0;
    logic [31:0] rx_tdata;
    logic        rx_tvalid;
    logic        rx_tlast;
    logic [7:0]  rx_bar_hit;
    logic        rx_tready;
    logic [31:0] tx_tdata;
    logic        tx_tvalid;
    logic        tx_tlast;
    logic        tx_tready;
    logic        turnoff_req = 1'b0;
    logic        turnoff_ok;
    logic [15:0] cid = 16'h0a51;
    int          n_errors = 0;
    int          n_tests = 0;
    int          overlap = 0;

    pio_target_responder pio_target_responder_inst (
        .i_core_clk(core_clk), .i_reset_n(reset_n), .i_rx_tdata(rx_tdata), .i_rx_tvalid(rx_tvalid),
        .i_rx_tlast(rx_tlast), .i_rx_bar_hit(rx_bar_hit), .o_rx_tready(rx_tready), .o_tx_tdata(tx_tdata),
        .o_tx_tvalid(tx_tvalid), .o_tx_tlast(tx_tlast), .i_tx_tready(tx_tready),
        .i_completer_id(cid), .i_turnoff_req(turnoff_req), .o_turnoff_ok(turnoff_ok));

    core_stream_model core_stream_model_inst (
        .i_core_clk(core_clk), .i_rx_tready(rx_tready), .i_tx_tdata(tx_tdata), .i_tx_tvalid(tx_tvalid),
        .i_tx_tlast(tx_tlast), .o_rx_tdata(rx_tdata), .o_rx_tvalid(rx_tvalid), .o_rx_tlast(rx_tlast),
        .o_rx_bar_hit(rx_bar_hit), .o_tx_tready(tx_tready));

    initial begin
        forever #25 core_clk = ~core_clk;
    end

    // receive must stay stalled while any completion is on the wire
    always @(negedge core_clk) begin
        if (tx_tvalid && rx_tready) overlap++;
    end

    // ==========================================================
    // helpers
    function automatic logic [31:0] dw0(input logic [1:0] fmt, input logic [4:0] typ, input logic [9:0] len);
        return {1'b0, fmt, typ, 1'b0, 3'h5, 4'h0, 2'h0, 2'h2, 2'h0, len};
    endfunction

    task automatic finish_test;
        $display("errors %0d checks %0d", n_errors, n_tests);
        if (n_errors == 0 && n_tests > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp) begin
            n_errors++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic stuck(input string what);
        n_errors++;
        $display("Error %s expected done seen timeout", what);
        finish_test();
    endtask

    task automatic req(input bit wr, input logic [7:0] bar, input logic [31:0] a, input logic [31:0] d,
                       input logic [3:0] be, input logic [7:0] tag, input logic [9:0] len);
        logic [31:0] dw [5];
        bit          ok;
        bit          wide;
        wide = (bar == 8'h02);
        dw[0] = dw0({wr, wide}, (bar == 8'h01) ? 5'h02 : 5'h00, len);
        dw[1] = {16'hbeef, tag, 4'h0, be};
        dw[2] = wide ? 32'h0 : a;
        dw[3] = wide ? a : d;
        dw[4] = d;
        core_stream_model_inst.send_tlp(dw, 3 + wide + wr + (wr && len == 10'h2), bar, ok);
        if (!ok) stuck("request accepted");
    endtask

    task automatic wait_cpl(input int n);
        int k;
        k = 0;
        while (core_stream_model_inst.cpl_q.size() < n && k < 200) begin
            @(posedge core_clk);
            k++;
        end
        if (core_stream_model_inst.cpl_q.size() < n) stuck("completion");
    endtask

    task automatic take(input logic [31:0] e [4], input int n, input logic [3:0] use_w);
        int          i;
        logic [31:0] w;
        logic        l;
        for (i = 0; i < n; i++) begin
            w = core_stream_model_inst.cpl_q.pop_front();
            l = core_stream_model_inst.end_q.pop_front();
            if (use_w[i]) chk("completion word", e[i], w);
            chk("completion last", {31'h0, i == n - 1}, {31'h0, l});
        end
    endtask

    task automatic rd(input logic [7:0] bar, input logic [31:0] a, input logic [3:0] be,
                      input logic [7:0] tag, input logic [31:0] d);
        logic [31:0] e [4];
        // byte count and first byte from the lane mask; only full and middle-pair masks are used
        e = '{dw0(pio_pkg::FMT_CPL_DATA, pio_pkg::TYPE_CPL, 10'h1),
              {cid, 4'h0, (be == 4'h6) ? 12'h002 : 12'h004},
              {16'hbeef, tag, 1'b0, a[6:2], (be == 4'h6) ? 2'h1 : 2'h0}, d};
        wait_cpl(4);
        take(e, 4, 4'hf);
    endtask

    task automatic quiet(input int n);
        repeat (10) @(posedge core_clk);
        chk("completion count", n, core_stream_model_inst.cpl_q.size());
    endtask

    // ==========================================================
    // scenarios
    task automatic t_reset;
        @(negedge core_clk);
        chk("ready after reset", 1, rx_tready);
        chk("tx valid after reset", 0, tx_tvalid);
        chk("turnoff ok after reset", 0, turnoff_ok);
        @(posedge core_clk);
    endtask

    task automatic t_regions;
        logic [7:0]  bars [4];
        logic [31:0] e [4];
        int          k;
        bars = '{8'h01, 8'h02, 8'h04, 8'h40};
        for (k = 0; k < 4; k++) begin
            req(1, bars[k], 32'h10, 32'hc0de_0000 + k, 4'hf, 8'h20, 10'h1);
            if (k == 0) begin
                e = '{dw0(pio_pkg::FMT_CPL_NODATA, pio_pkg::TYPE_CPL, 10'h0), {cid, 4'h0, 12'h004},
                      {16'hbeef, 8'h20, 1'b0, 7'h10}, 0};
                wait_cpl(3);
                take(e, 3, 4'h7);
            end
            quiet(0);
        end
        // bit 11 set lands on the same 2 KB word
        for (k = 0; k < 4; k++) begin
            req(0, bars[k], 32'h810, 0, 4'hf, 8'h30 + k, 10'h1);
            rd(bars[k], 32'h810, 4'hf, 8'h30 + k, 32'hc0de_0000 + k);
        end
    endtask

    task automatic t_partial;
        req(1, 8'h04, 32'h10, 32'hffff_ffff, 4'h3, 8'h40, 10'h1);
        req(0, 8'h04, 32'h10, 0, 4'hf, 8'h41, 10'h1);
        rd(8'h04, 32'h10, 4'hf, 8'h41, 32'hc0de_ffff);
        req(0, 8'h04, 32'h10, 0, 4'h6, 8'h42, 10'h1);
        rd(8'h04, 32'h10, 4'h6, 8'h42, 32'h00de_ff00);
    endtask

    task automatic t_back_to_back;
        core_stream_model_inst.slow = 1'b1;
        req(0, 8'h04, 32'h10, 0, 4'hf, 8'h51, 10'h1);
        req(0, 8'h40, 32'h14, 0, 4'hf, 8'h52, 10'h1);
        wait_cpl(8);
        rd(8'h04, 32'h10, 4'hf, 8'h51, 32'hc0de_ffff);
        rd(8'h40, 32'h14, 4'hf, 8'h52, 32'h0000_0000);
        core_stream_model_inst.slow = 1'b0;
        chk("ready during completion", 0, overlap);
    endtask

    task automatic t_long;
        req(1, 8'h40, 32'h14, 32'h1111_2222, 4'hf, 8'h60, 10'h2);
        quiet(0);
        req(0, 8'h40, 32'h14, 0, 4'hf, 8'h61, 10'h2);
        quiet(0);
        // the dropped long write must have left this word untouched
        req(0, 8'h40, 32'h14, 0, 4'hf, 8'h62, 10'h1);
        rd(8'h40, 32'h14, 4'hf, 8'h62, 32'h0000_0000);
    endtask

    task automatic t_turnoff;
        turnoff_req <= 1'b1;
        repeat (3) @(posedge core_clk);
        @(negedge core_clk);
        chk("turnoff ack", 1, turnoff_ok);
        @(posedge core_clk);
        turnoff_req <= 1'b0;
        repeat (3) @(posedge core_clk);
        @(negedge core_clk);
        chk("turnoff ack released", 0, turnoff_ok);
        @(posedge core_clk);
    endtask

    initial begin
        repeat (16) @(posedge core_clk);
        reset_n <= 1'b1;
        @(posedge core_clk);
        t_reset();
        req(1, 8'h40, 32'h14, 32'h0, 4'hf, 8'h10, 10'h1);
        t_regions();
        t_partial();
        t_back_to_back();
        t_long();
        t_turnoff();
        finish_test();
    end
endmodule

// [verilog/pio_pkg.sv]
// constants, field layouts and types for the pio target responder
// assumes a 32-bit transaction stream from the endpoint core
package pio_pkg;
    localparam int          DATA_W       = 32;
    localparam int          MEM_WORDS    = 2048;
    // region codes form the top two bits of the 11-bit word address
    localparam logic [1:0]  REGION_IO    = 2'h0;
    localparam logic [1:0]  REGION_MEM32 = 2'h1;
    localparam logic [1:0]  REGION_MEM64 = 2'h2;
    localparam logic [1:0]  REGION_EROM  = 2'h3;
    localparam int          HIT_IO       = 0;
    localparam int          HIT_MEM64    = 1;
    localparam int          HIT_MEM32    = 2;
    localparam int          HIT_EROM     = 6;
    localparam logic [7:0]  HIT_MEM32_CODE = 8'h04;
    localparam logic [4:0]  TYPE_MEM     = 5'h00;
    localparam logic [4:0]  TYPE_IO      = 5'h02;
    localparam logic [4:0]  TYPE_CPL     = 5'h0a;
    localparam logic [1:0]  FMT_CPL_NODATA = 2'h0;
    localparam logic [1:0]  FMT_CPL_DATA = 2'h2;
    localparam logic [9:0]  ONE_DW_LEN   = 10'h001;
    localparam logic [9:0]  ZERO_LEN     = 10'h000;
    localparam logic [11:0] IO_WR_COUNT  = 12'h004;
    localparam logic [2:0]  STATUS_OK    = 3'h0;
    localparam int          POS_FMT      = 29;
    localparam int          POS_TYPE     = 24;
    localparam int          POS_TC       = 20;
    localparam int          POS_TD       = 15;
    localparam int          POS_EP       = 14;
    localparam int          POS_ATTR     = 12;
    localparam int          POS_RID      = 16;
    localparam int          POS_TAG      = 8;
    localparam int          POS_WORD     = 2;
    localparam logic        RESET_READY  = 1'b1;

    typedef struct packed {
        logic        td;
        logic        ep;
        logic [2:0]  tc;
        logic [1:0]  attr;
        logic [9:0]  len;
        logic [15:0] rid;
        logic [7:0]  tag;
        logic [7:0]  be;
        logic [10:0] addr;
    } req_info_type;

    typedef struct packed {
        logic [10:0] addr;
        logic [7:0]  be;
        logic [31:0] data;
    } wr_req_type;

    typedef enum logic [7:0] {
        ST_IDLE     = 8'h01,
        ST_DW1      = 8'h02,
        ST_DW2      = 8'h04,
        ST_DW3      = 8'h08,
        ST_DATA     = 8'h10,
        ST_WAIT_WR  = 8'h20,
        ST_WAIT_CPL = 8'h40,
        ST_DRAIN    = 8'h80
    } rx_state_type;

    typedef enum logic [4:0] {
        TX_IDLE = 5'h01,
        TX_DW0  = 5'h02,
        TX_DW1  = 5'h04,
        TX_DW2  = 5'h08,
        TX_DW3  = 5'h10
    } tx_state_type;
endpackage

// [verilog/pio_target_responder.sv]
// pio target: rx parser, 4 x 2 KB regions, completion builder, turn-off ack
// assumes the core only forwards bar-matched packets, one packet per tlast
`timescale 1ns/100ps

module pio_target_responder (
    input  wire logic        i_core_clk,
    input  wire logic        i_reset_n,
    input  wire logic [31:0] i_rx_tdata,
    input  wire logic        i_rx_tvalid,
    input  wire logic        i_rx_tlast,
    input  wire logic [7:0]  i_rx_bar_hit,
    output logic             o_rx_tready,
    output logic [31:0]      o_tx_tdata,
    output logic             o_tx_tvalid,
    output logic             o_tx_tlast,
    input  wire logic        i_tx_tready,
    input  wire logic [15:0] i_completer_id,
    input  wire logic        i_turnoff_req,
    output logic             o_turnoff_ok
);
    pio_pkg::rx_state_type rx_state;
    pio_pkg::rx_state_type next_rx_state;
    pio_pkg::tx_state_type tx_state;
    pio_pkg::req_info_type req;
    pio_pkg::wr_req_type   wr;
    logic [1:0]            region;
    logic                  is_read;
    logic                  is_io;
    logic                  is_64;
    logic                  req_compl;
    logic                  wr_en;
    logic                  wr_busy;
    logic                  compl_done;
    logic [31:0]           rd_data;
    logic [31:0]           mem [0:pio_pkg::MEM_WORDS-1];

    // ======================================================
    // receive decode
    // fixed at the 32-bit stream width of the attached core
    wire       beat     = i_rx_tvalid & o_rx_tready;
    wire [1:0] dw0_fmt  = i_rx_tdata[pio_pkg::POS_FMT +: 2];
    wire [4:0] dw0_type = i_rx_tdata[pio_pkg::POS_TYPE +: 5];
    wire [9:0] dw0_len  = i_rx_tdata[9:0];
    wire       hit_any  = i_rx_bar_hit[pio_pkg::HIT_IO] | i_rx_bar_hit[pio_pkg::HIT_MEM64]
                        | i_rx_bar_hit[pio_pkg::HIT_MEM32] | i_rx_bar_hit[pio_pkg::HIT_EROM];
    wire [1:0] hit_region = i_rx_bar_hit[pio_pkg::HIT_IO]    ? pio_pkg::REGION_IO
                          : i_rx_bar_hit[pio_pkg::HIT_MEM32] ? pio_pkg::REGION_MEM32
                          : i_rx_bar_hit[pio_pkg::HIT_MEM64] ? pio_pkg::REGION_MEM64
                          : pio_pkg::REGION_EROM;
    wire dw0_ok = (dw0_type == pio_pkg::TYPE_MEM || (dw0_type == pio_pkg::TYPE_IO && !dw0_fmt[0]))
                  && dw0_len == pio_pkg::ONE_DW_LEN && hit_any;
    wire addr_beat = beat & ((rx_state == pio_pkg::ST_DW2 & !is_64) | rx_state == pio_pkg::ST_DW3);
    // upper offset bits dropped so wide apertures alias the 2 KB region
    wire [10:0] beat_addr = {region, i_rx_tdata[pio_pkg::POS_WORD +: 9]};
    wire wr_idle = !wr_en & !wr_busy;
    wire next_req_compl = (addr_beat & is_read)
                        | (rx_state == pio_pkg::ST_WAIT_WR & wr_idle & is_io);
    wire next_ready = next_rx_state != pio_pkg::ST_WAIT_WR && next_rx_state != pio_pkg::ST_WAIT_CPL;
    wire pio_pkg::rx_state_type after_addr = is_read ? pio_pkg::ST_WAIT_CPL
                                           : i_rx_tlast ? pio_pkg::ST_IDLE : pio_pkg::ST_DATA;

    always_comb begin
        next_rx_state = rx_state;
        case (rx_state)
            pio_pkg::ST_IDLE: begin
                if (beat && !i_rx_tlast) next_rx_state = dw0_ok ? pio_pkg::ST_DW1 : pio_pkg::ST_DRAIN;
            end
            pio_pkg::ST_DW1: begin
                if (beat) next_rx_state = i_rx_tlast ? pio_pkg::ST_IDLE : pio_pkg::ST_DW2;
            end
            pio_pkg::ST_DW2: begin
                if (beat) next_rx_state = is_64 ? pio_pkg::ST_DW3 : after_addr;
            end
            pio_pkg::ST_DW3: begin
                if (beat) next_rx_state = after_addr;
            end
            pio_pkg::ST_DATA: begin
                if (beat) next_rx_state = pio_pkg::ST_WAIT_WR;
            end
            pio_pkg::ST_WAIT_WR: begin
                if (wr_idle) next_rx_state = is_io ? pio_pkg::ST_WAIT_CPL : pio_pkg::ST_IDLE;
            end
            pio_pkg::ST_WAIT_CPL: begin
                if (compl_done) next_rx_state = pio_pkg::ST_IDLE;
            end
            pio_pkg::ST_DRAIN: begin
                if (beat && i_rx_tlast) next_rx_state = pio_pkg::ST_IDLE;
            end
            default: next_rx_state = pio_pkg::ST_IDLE;
        endcase
    end

    always_ff @(posedge i_core_clk) begin
        if (!i_reset_n) begin
            rx_state    <= pio_pkg::ST_IDLE;
            o_rx_tready <= pio_pkg::RESET_READY;
            req_compl   <= 1'b0;
            wr_en       <= 1'b0;
        end else begin
            rx_state    <= next_rx_state;
            o_rx_tready <= next_ready;
            req_compl   <= next_req_compl;
            wr_en       <= beat & (rx_state == pio_pkg::ST_DATA);
        end
    end

    // ======================================================
    // request field capture
    always_ff @(posedge i_core_clk) begin
        if (beat && rx_state == pio_pkg::ST_IDLE) begin
            region   <= hit_region;
            is_read  <= !dw0_fmt[1];
            is_io    <= dw0_type == pio_pkg::TYPE_IO;
            is_64    <= dw0_fmt[0];
            req.td   <= i_rx_tdata[pio_pkg::POS_TD];
            req.ep   <= i_rx_tdata[pio_pkg::POS_EP];
            req.tc   <= i_rx_tdata[pio_pkg::POS_TC +: 3];
            req.attr <= i_rx_tdata[pio_pkg::POS_ATTR +: 2];
            req.len  <= dw0_len;
        end
        if (beat && rx_state == pio_pkg::ST_DW1) begin
            req.rid <= i_rx_tdata[pio_pkg::POS_RID +: 16];
            req.tag <= i_rx_tdata[pio_pkg::POS_TAG +: 8];
            req.be  <= i_rx_tdata[7:0];
        end
        if (addr_beat) begin
            req.addr <= beat_addr;
            wr.addr  <= beat_addr;
        end
        if (beat && rx_state == pio_pkg::ST_DATA) begin
            wr.data <= i_rx_tdata;
            wr.be   <= req.be;
        end
    end

    // ======================================================
    // memory access unit
    logic [31:0] rd_mask;
    genvar lane;
    generate
        for (lane = 0; lane < 4; lane = lane + 1) begin : g_lane
            assign rd_mask[8*lane +: 8] = {8{req.be[lane]}};
        end
    endgenerate

    always_ff @(posedge i_core_clk) begin
        if (!i_reset_n) begin
            wr_busy <= 1'b0;
        end else begin
            wr_busy <= wr_en;
        end
    end

    // write lands in the busy cycle, so a following read always sees it
    always_ff @(posedge i_core_clk) begin
        if (wr_busy) begin
            for (int b = 0; b < 4; b++) begin
                if (wr.be[b]) mem[wr.addr][8*b +: 8] <= wr.data[8*b +: 8];
            end
        end
        if (req_compl && is_read) rd_data <= mem[req.addr] & rd_mask;
    end

    // ======================================================
    // completion builder
    function automatic logic [11:0] one_dw_count(input logic [3:0] be);
        casez (be)
            4'b1??1:                   return 12'h004;
            4'b01?1, 4'b1?10:          return 12'h003;
            4'b0011, 4'b0110, 4'b1100: return 12'h002;
            default:                   return 12'h001;
        endcase
    endfunction

    function automatic logic [1:0] first_byte(input logic [3:0] be);
        casez (be)
            4'b???1: return 2'h0;
            4'b??10: return 2'h1;
            4'b?100: return 2'h2;
            4'b1000: return 2'h3;
            default: return 2'h0;
        endcase
    endfunction

    wire [11:0] byte_cnt = is_read ? one_dw_count(req.be[3:0]) : pio_pkg::IO_WR_COUNT;
    wire [6:0]  low_addr = {req.addr[4:0], first_byte(req.be[3:0])};
    // digest is never appended, so td goes out clear
    wire [31:0] cpl_w0 = {1'b0, is_read ? pio_pkg::FMT_CPL_DATA : pio_pkg::FMT_CPL_NODATA,
                          pio_pkg::TYPE_CPL, 1'b0, req.tc, 4'h0, 1'b0, req.ep, req.attr, 2'h0,
                          is_read ? pio_pkg::ONE_DW_LEN : pio_pkg::ZERO_LEN};
    wire [31:0] cpl_w1 = {i_completer_id, pio_pkg::STATUS_OK, 1'b0, byte_cnt};
    wire [31:0] cpl_w2 = {req.rid, req.tag, 1'b0, low_addr};

    always_ff @(posedge i_core_clk) begin
        if (!i_reset_n) begin
            tx_state    <= pio_pkg::TX_IDLE;
            o_tx_tdata  <= 32'h0000_0000;
            o_tx_tvalid <= 1'b0;
            o_tx_tlast  <= 1'b0;
            compl_done  <= 1'b0;
        end else begin
            compl_done <= 1'b0;
            case (tx_state)
                pio_pkg::TX_IDLE: if (req_compl) begin
                    o_tx_tdata  <= cpl_w0;
                    o_tx_tvalid <= 1'b1;
                    tx_state    <= pio_pkg::TX_DW0;
                end
                pio_pkg::TX_DW0: if (i_tx_tready) begin
                    o_tx_tdata <= cpl_w1;
                    tx_state   <= pio_pkg::TX_DW1;
                end
                pio_pkg::TX_DW1: if (i_tx_tready) begin
                    o_tx_tdata <= cpl_w2;
                    o_tx_tlast <= !is_read;
                    tx_state   <= pio_pkg::TX_DW2;
                end
                pio_pkg::TX_DW2: if (i_tx_tready) begin
                    if (is_read) begin
                        o_tx_tdata <= rd_data;
                        o_tx_tlast <= 1'b1;
                        tx_state   <= pio_pkg::TX_DW3;
                    end else begin
                        o_tx_tvalid <= 1'b0;
                        o_tx_tlast  <= 1'b0;
                        compl_done  <= 1'b1;
                        tx_state    <= pio_pkg::TX_IDLE;
                    end
                end
                pio_pkg::TX_DW3: if (i_tx_tready) begin
                    o_tx_tvalid <= 1'b0;
                    o_tx_tlast  <= 1'b0;
                    compl_done  <= 1'b1;
                    tx_state    <= pio_pkg::TX_IDLE;
                end
                default: tx_state <= pio_pkg::TX_IDLE;
            endcase
        end
    end

    // ======================================================
    // turn-off responder: ack only once nothing is in flight
    wire quiet = rx_state == pio_pkg::ST_IDLE && tx_state == pio_pkg::TX_IDLE && !req_compl;

    always_ff @(posedge i_core_clk) begin
        if (!i_reset_n) o_turnoff_ok <= 1'b0;
        else o_turnoff_ok <= i_turnoff_req & quiet;
    end

    // ======================================================
    // assertions
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (!i_reset_n);

    sequence s_cpl_start;
        req_compl ##1 (o_tx_tvalid && tx_state == pio_pkg::TX_DW0);
    endsequence
    sequence s_write_pulse;
        wr_busy ##1 !wr_busy;
    endsequence

    property p_read_answered;
        addr_beat && is_read |=> s_cpl_start;
    endproperty
    a_read_answered: assert property (p_read_answered) else $error("read not answered");
    property p_stall_read;
        rx_state == pio_pkg::ST_WAIT_CPL |-> !o_rx_tready;
    endproperty
    a_stall_read: assert property (p_stall_read) else $error("ready high during read");
    property p_resume;
        compl_done && rx_state == pio_pkg::ST_WAIT_CPL |=> rx_state == pio_pkg::ST_IDLE && o_rx_tready;
    endproperty
    a_resume: assert property (p_resume) else $error("no resume after completion");
    property p_wr_hold;
        rx_state == pio_pkg::ST_WAIT_WR && !wr_idle |=> rx_state == pio_pkg::ST_WAIT_WR;
    endproperty
    a_wr_hold: assert property (p_wr_hold) else $error("write left early");
    property p_busy;
        wr_en |=> s_write_pulse;
    endproperty
    a_busy: assert property (p_busy) else $error("busy pulse wrong");
    property p_done;
        o_tx_tvalid && i_tx_tready && o_tx_tlast |=> compl_done && !o_tx_tvalid;
    endproperty
    a_done: assert property (p_done) else $error("completion-sent missing");
    property p_only_cpl;
        tx_state == pio_pkg::TX_DW0 |-> o_tx_tdata[pio_pkg::POS_TYPE +: 5] == pio_pkg::TYPE_CPL;
    endproperty
    a_only_cpl: assert property (p_only_cpl) else $error("non-completion sent");
    property p_mem32;
        beat && rx_state == pio_pkg::ST_IDLE && i_rx_bar_hit == pio_pkg::HIT_MEM32_CODE
            |=> region == pio_pkg::REGION_MEM32;
    endproperty
    a_mem32: assert property (p_mem32) else $error("bar 2 not mem32");
    property p_drain;
        beat && rx_state == pio_pkg::ST_IDLE && !i_rx_tlast && dw0_len != pio_pkg::ONE_DW_LEN
            |=> rx_state == pio_pkg::ST_DRAIN && !req_compl;
    endproperty
    a_drain: assert property (p_drain) else $error("long packet not drained");
    property p_turnoff;
        i_turnoff_req && quiet |=> o_turnoff_ok;
    endproperty
    a_turnoff: assert property (p_turnoff) else $error("turn-off not acked");
    property p_reset_idle;
        @(posedge i_core_clk) disable iff (1'b0)
        !i_reset_n |=> o_rx_tready && rx_state == pio_pkg::ST_IDLE && !o_tx_tvalid;
    endproperty
    a_reset_idle: assert property (p_reset_idle) else $error("reset not idle");
endmodule
